// File: logic/dbg_regs.svh
`ifndef DBG_REGS_SVH
`define DBG_REGS_SVH

// Debug control register numbers
`define DRC_ABH         5'h0c
`define DRC_ABL         5'h0d
`define DRC_TRIG_DEF    5'h07
`define DRC_STATUS      5'h00

// Trigger definition fields
`define TDEF_RESP_HI    31
`define TDEF_RESP_LO    30
`define TDEF_EN2        29
`define TDEF_MOD2_HI    18
`define TDEF_MOD2_LO    16
`define TDEF_COMB2      15
`define TDEF_COMB1      14
`define TDEF_EN1        13
`define TDEF_AM2_HI     22
`define TDEF_AM2_LO     21
`define TDEF_TYPE2_HI   20
`define TDEF_TYPE2_LO   19
`define TDEF_AM1_HI     6
`define TDEF_AM1_LO     5
`define TDEF_TYPE1_HI   4
`define TDEF_TYPE1_LO   3
`define TDEF_MOD1_HI    2
`define TDEF_MOD1_LO    0
`define TDEF_RESET      32'h0000_0000

// Trigger responses
`define RESP_DISPLAY    2'h0
`define RESP_HALT       2'h1
`define RESP_IRQ        2'h2

// Address match modes
`define AM_OFF          2'h0
`define AM_EQUAL        2'h1
`define AM_INSIDE       2'h2
`define AM_OUTSIDE      2'h3

// Breakpoint status codes and the data pin pattern on a trigger
`define BST_IDLE        4'h0
`define BST_L1_HIT      4'h2
`define BST_FIRED       4'h3
`define PINS_TRIG       4'hf

// Response packets
`define RSP_OK          17'h0_ffff
`define RSP_NOT_READY   17'h1_0000
`define RSP_BUS_ERROR   17'h1_0001
`define RSP_ILLEGAL     17'h1_ffff

// Command opcodes in bits 15..8
`define CMD_RD_REG      8'h2d
`define CMD_WR_REG      8'h2c

// Serial timing
`define PKT_BITS        5'h11
`define HOLD_CYCLES     6'h20

`endif

// File: logic/dbg_pkg.sv
package dbg_pkg;
    typedef logic [16:0] packet_t;
    typedef enum logic [1:0] {CMD_IDLE, CMD_WR_HI, CMD_WR_LO, CMD_RD_LO} cmd_state_t;
endpackage : dbg_pkg

// File: logic/serial_if.sv
`timescale 1ns/100ps
interface serial_if;
    logic [16:0] rx_word;
    logic        rx_done;
    logic [16:0] tx_word;
    modport shifter (output rx_word, output rx_done, input tx_word);
    modport core    (input rx_word, input rx_done, output tx_word);
endinterface : serial_if

// File: logic/serial_shifter.sv
`timescale 1ns/100ps
`include "dbg_regs.svh"
module serial_shifter
    import dbg_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   rst_n,
    input  wire logic   dev_serial_clock,
    input  wire logic   dev_serial_in,
    output logic        dev_serial_out_q,
    serial_if.shifter   link
);
    logic [2:0]  sclk_q;
    logic [2:0]  sin_q;
    logic [4:0]  cnt_q;
    logic [16:0] rx_q;
    logic [15:0] tx_sh_q;
    logic        done_q;
    logic        edge_w;
    logic        sclk_lvl_q;

    // Level moves only once stages two and three agree; a one-clock glitch is ignored
    assign edge_w       = sclk_q[2] & sclk_q[1] & ~sclk_lvl_q;
    assign link.rx_word = rx_q;
    assign link.rx_done = done_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q     <= 3'h0;
            sclk_lvl_q <= 1'b0;
            sin_q  <= 3'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], dev_serial_clock};
            sclk_lvl_q <= (sclk_q[2] == sclk_q[1]) ? sclk_q[2] : sclk_lvl_q;
            sin_q  <= {sin_q[1:0], dev_serial_in};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q            <= 5'h0;
            rx_q             <= 17'h0;
            tx_sh_q          <= 16'h0;
            dev_serial_out_q <= 1'b0;
            done_q           <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (edge_w) begin
                rx_q             <= {rx_q[15:0], sin_q[2]};
                dev_serial_out_q <= tx_sh_q[15];
                tx_sh_q          <= {tx_sh_q[14:0], 1'b0};
                if (cnt_q == `PKT_BITS - 5'h1) begin
                    cnt_q  <= 5'h0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 5'h1;
                end
            end else if (cnt_q == 5'h0) begin
                // Idle: first bit waits on the pin before the first edge
                dev_serial_out_q <= link.tx_word[16];
                tx_sh_q          <= link.tx_word[15:0];
            end
        end
    end

    a_packet_len: assert property (@(posedge clock) disable iff (!rst_n)
        done_q |-> $past(cnt_q) == 5'h10)
        else $error("packet ended after wrong bit count");
    a_out_on_edge: assert property (@(posedge clock) disable iff (!rst_n)
        (!edge_w && cnt_q != 5'h0) |=> $stable(dev_serial_out_q))
        else $error("serial out moved without a clock edge");
endmodule : serial_shifter

// File: logic/debug_breakpoint_serial_port.sv
// What this block does
// - Compare bus addresses with low/high limits: equal, inside inclusive, or outside.
// - High limit is read/write, debug register 0x0C, serial read and write.
// - Low limit is write-only, undefined at reset, debug register 0x0D, serial write.
// - A trigger definition write clears the breakpoint status bits unless a trigger fires in the same cycle.
// - Bits 31:30 pick display, halt or interrupt; data pins always show triggers.
// - Bits 15/14: 0 ANDs all conditions, 1 ORs PC with address-and-data.
// - Bits 29/13 enable triggering for level two and level one.
// - Bits 2:0 compare against the bus transfer modifier.
// - Responses are 17 bits: status bit plus data, OK, not-ready, illegal; the bus error code is never sent.
// - New serial transfer accepted 32 clocks after the previous one.
// - Each serial clock rising edge samples input and updates output.
`timescale 1ns/100ps
`include "dbg_regs.svh"
module debug_breakpoint_serial_port
    import dbg_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        bus_valid,
    input  wire logic [31:0] bus_addr,
    input  wire logic [2:0]  xfer_modifier_field,
    input  wire logic [1:0]  xfer_type_field,
    input  wire logic        pc_cond_l1,
    input  wire logic        pc_cond_l2,
    input  wire logic        data_cond_l1,
    input  wire logic        data_cond_l2,
    input  wire logic        debug_write_instr_valid,
    input  wire logic [4:0]  debug_write_instr_reg,
    input  wire logic [31:0] debug_write_instr_data,
    input  wire logic        dev_serial_clock,
    input  wire logic        dev_serial_in,
    output logic             dev_serial_out,
    output logic [3:0]       debug_data_pins,
    output logic             halt_req,
    output logic             debug_irq
);
    serial_if link ();

    logic [31:0] addr_bkpt_high;
    logic [31:0] addr_bkpt_low;
    logic [31:0] trigger_definition_reg_q;
    logic [3:0]  bkpt_status_q;
    cmd_state_t  cmd_q;
    logic [4:0]  cmd_reg_q;
    logic [15:0] wr_hi_q;
    logic [15:0] rd_lo_q;
    packet_t     resp_q;
    packet_t     tx_q;
    logic [5:0]  hold_q;
    logic        halt_q;
    logic        irq_q;
    logic [3:0]  pins_q;
    logic        wr_en;
    logic [4:0]  wr_reg;
    logic [31:0] wr_data;
    logic        ser_wr;
    logic        in_range;
    logic        a1_hit;
    logic        a2_hit;
    logic        l1_cond;
    logic        l2_cond;
    logic        en1;
    logic        en2;
    logic        fire;
    logic [1:0]  resp_sel;

    serial_shifter u_shift (
        .clock            (clock),
        .rst_n            (rst_n),
        .dev_serial_clock (dev_serial_clock),
        .dev_serial_in    (dev_serial_in),
        .dev_serial_out_q (dev_serial_out),
        .link             (link.shifter)
    );

    assign link.tx_word    = tx_q;
    assign debug_data_pins = pins_q;
    assign halt_req        = halt_q;
    assign debug_irq       = irq_q;

    function automatic logic addr_match(input logic [1:0] mode, input logic [2:0] tm, input logic [1:0] tt,
                                        input logic rng);
        logic hit;
        hit = 1'b0;
        case (mode)
            `AM_EQUAL:   hit = (bus_addr == addr_bkpt_low);
            `AM_INSIDE:  hit = rng;
            `AM_OUTSIDE: hit = !rng;
            default:     hit = 1'b0;
        endcase
        return hit && bus_valid && (tm == xfer_modifier_field) && (tt == xfer_type_field);
    endfunction : addr_match

    assign in_range = (bus_addr >= addr_bkpt_low) && (bus_addr <= addr_bkpt_high);
    assign a1_hit   = addr_match(trigger_definition_reg_q[`TDEF_AM1_HI:`TDEF_AM1_LO],
                                 trigger_definition_reg_q[`TDEF_MOD1_HI:`TDEF_MOD1_LO],
                                 trigger_definition_reg_q[`TDEF_TYPE1_HI:`TDEF_TYPE1_LO], in_range);
    assign a2_hit   = addr_match(trigger_definition_reg_q[`TDEF_AM2_HI:`TDEF_AM2_LO],
                                 trigger_definition_reg_q[`TDEF_MOD2_HI:`TDEF_MOD2_LO],
                                 trigger_definition_reg_q[`TDEF_TYPE2_HI:`TDEF_TYPE2_LO], in_range);
    assign l1_cond  = trigger_definition_reg_q[`TDEF_COMB1] ? (pc_cond_l1 | (a1_hit & data_cond_l1))
                                                            : (pc_cond_l1 & a1_hit & data_cond_l1);
    assign l2_cond  = trigger_definition_reg_q[`TDEF_COMB2] ? (pc_cond_l2 | (a2_hit & data_cond_l2))
                                                            : (pc_cond_l2 & a2_hit & data_cond_l2);
    assign en1      = trigger_definition_reg_q[`TDEF_EN1];
    assign en2      = trigger_definition_reg_q[`TDEF_EN2];
    // Both levels enabled: level one arms, level two completes
    assign fire     = (en1 && en2) ? (bkpt_status_q == `BST_L1_HIT && l2_cond)
                                   : ((en1 && l1_cond) || (en2 && l2_cond));
    assign resp_sel = trigger_definition_reg_q[`TDEF_RESP_HI:`TDEF_RESP_LO];

    // Debug-write instruction wins; overlapping serial writes are undefined anyway
    assign ser_wr  = link.rx_done && cmd_q == CMD_WR_LO;
    assign wr_en   = debug_write_instr_valid || ser_wr;
    assign wr_reg  = debug_write_instr_valid ? debug_write_instr_reg : cmd_reg_q;
    assign wr_data = debug_write_instr_valid ? debug_write_instr_data : {wr_hi_q, link.rx_word[15:0]};

    // Address limits keep no reset value
    always_ff @(posedge clock) begin
        if (wr_en && wr_reg == `DRC_ABH) begin
            addr_bkpt_high <= wr_data;
        end
        if (wr_en && wr_reg == `DRC_ABL) begin
            addr_bkpt_low <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trigger_definition_reg_q <= `TDEF_RESET;
        end else if (wr_en && wr_reg == `DRC_TRIG_DEF) begin
            trigger_definition_reg_q <= wr_data;
        end
    end

    // A trigger in the same cycle as a definition write is kept
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bkpt_status_q <= `BST_IDLE;
        end else if (fire) begin
            bkpt_status_q <= `BST_FIRED;
        end else if (wr_en && wr_reg == `DRC_TRIG_DEF) begin
            bkpt_status_q <= `BST_IDLE;
        end else if (en1 && en2 && l1_cond && bkpt_status_q == `BST_IDLE) begin
            bkpt_status_q <= `BST_L1_HIT;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pins_q  <= 4'h0;
            halt_q  <= 1'b0;
            irq_q   <= 1'b0;
        end else begin
            pins_q  <= fire ? `PINS_TRIG : 4'h0;
            halt_q  <= fire && resp_sel == `RESP_HALT;
            irq_q   <= fire && resp_sel == `RESP_IRQ;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q     <= CMD_IDLE;
            cmd_reg_q <= 5'h0;
            wr_hi_q   <= 16'h0;
            rd_lo_q   <= 16'h0;
            resp_q    <= `RSP_OK;
        end else if (link.rx_done) begin
            case (cmd_q)
                CMD_IDLE: begin
                    cmd_reg_q <= link.rx_word[4:0];
                    if (link.rx_word[16]) begin
                        resp_q <= `RSP_ILLEGAL;
                    end else if (link.rx_word[15:8] == `CMD_WR_REG &&
                                 (link.rx_word[4:0] == `DRC_ABH || link.rx_word[4:0] == `DRC_ABL ||
                                  link.rx_word[4:0] == `DRC_TRIG_DEF)) begin
                        cmd_q  <= CMD_WR_HI;
                        resp_q <= `RSP_NOT_READY;
                    end else if (link.rx_word[15:8] == `CMD_RD_REG && link.rx_word[4:0] == `DRC_ABH) begin
                        cmd_q   <= CMD_RD_LO;
                        resp_q  <= {1'b0, addr_bkpt_high[31:16]};
                        rd_lo_q <= addr_bkpt_high[15:0];
                    end else if (link.rx_word[15:8] == `CMD_RD_REG && link.rx_word[4:0] == `DRC_TRIG_DEF) begin
                        cmd_q   <= CMD_RD_LO;
                        resp_q  <= {1'b0, trigger_definition_reg_q[31:16]};
                        rd_lo_q <= trigger_definition_reg_q[15:0];
                    end else if (link.rx_word[15:8] == `CMD_RD_REG && link.rx_word[4:0] == `DRC_STATUS) begin
                        cmd_q   <= CMD_RD_LO;
                        resp_q  <= {1'b0, bkpt_status_q, 12'h000};
                        rd_lo_q <= 16'h0000;
                    end else begin
                        resp_q <= `RSP_ILLEGAL;
                    end
                end
                CMD_WR_HI: begin
                    wr_hi_q <= link.rx_word[15:0];
                    cmd_q   <= CMD_WR_LO;
                end
                CMD_WR_LO: begin
                    resp_q <= `RSP_OK;
                    cmd_q  <= CMD_IDLE;
                end
                CMD_RD_LO: begin
                    resp_q <= {1'b0, rd_lo_q};
                    cmd_q  <= CMD_IDLE;
                end
                default: begin
                    cmd_q <= CMD_IDLE;
                end
            endcase
        end
    end

    // Shift out not-ready until the settle window after a packet has passed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= 6'h0;
            tx_q   <= `RSP_OK;
        end else begin
            if (link.rx_done) begin
                hold_q <= `HOLD_CYCLES;
            end else if (hold_q != 6'h0) begin
                hold_q <= hold_q - 6'h1;
            end
            tx_q <= (link.rx_done || hold_q > 6'h1) ? `RSP_NOT_READY : resp_q;
        end
    end

    sequence s_hold_run;
        hold_q == 6'h20 ##31 hold_q == 6'h1 ##1 hold_q == 6'h0;
    endsequence

    a_hold_count: assert property (@(posedge clock) disable iff (!rst_n)
        link.rx_done |=> s_hold_run)
        else $error("settle window is not 32 cycles");
    a_hold_nready: assert property (@(posedge clock) disable iff (!rst_n)
        (hold_q > 6'h1) |=> tx_q == `RSP_NOT_READY)
        else $error("response offered during settle window");
    a_defwrite_clears: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_en && wr_reg == `DRC_TRIG_DEF && !fire) |=> bkpt_status_q == `BST_IDLE)
        else $error("status survived definition write");
    a_halt_resp: assert property (@(posedge clock) disable iff (!rst_n)
        fire |=> (halt_q == ($past(resp_sel) == `RESP_HALT)) && (irq_q == ($past(resp_sel) == `RESP_IRQ))
                 && pins_q == `PINS_TRIG)
        else $error("trigger response mismatch");
    a_disabled_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        (!en1 && !en2) |-> !fire)
        else $error("trigger with both levels disabled");
    a_addr_equal: assert property (@(posedge clock) disable iff (!rst_n)
        (a1_hit && trigger_definition_reg_q[`TDEF_AM1_HI:`TDEF_AM1_LO] == `AM_EQUAL) |-> bus_addr == addr_bkpt_low)
        else $error("equal match on different address");
    a_illegal_resp: assert property (@(posedge clock) disable iff (!rst_n)
        (link.rx_done && cmd_q == CMD_IDLE && link.rx_word[16]) |=> resp_q == `RSP_ILLEGAL)
        else $error("control bit set but not illegal");
    a_modifier_gate: assert property (@(posedge clock) disable iff (!rst_n)
        a1_hit |-> xfer_modifier_field == trigger_definition_reg_q[`TDEF_MOD1_HI:`TDEF_MOD1_LO])
        else $error("address hit with wrong modifier");
endmodule : debug_breakpoint_serial_port

// File: sim/dev_system_model.sv
`timescale 1ns/100ps
module dev_system_model
    import dbg_pkg::*;
(
    output logic     dev_serial_clock,
    output logic     dev_serial_in,
    input wire logic dev_serial_out
);
    initial begin
        dev_serial_clock = 1'b0;
        dev_serial_in    = 1'b1;
    end

    // Clock stands still between packets; both words cross together
    task automatic xfer(input packet_t cmd, input realtime gap, input realtime half,
                        output packet_t rsp);
        #(gap); // Spacing after the previous packet
        for (int i = 16; i >= 0; i--) begin
            dev_serial_in = cmd[i]; // Bit 16 low unless a test breaks it
            #(half);
            rsp[i] = dev_serial_out;
            dev_serial_clock = 1'b1; // Half period 62.5 ns or more, under a fifth
            #(half);
            dev_serial_clock = 1'b0;
        end
        dev_serial_in = ~cmd[0]; // Released line never shows a stale bit
    endtask : xfer
endmodule : dev_system_model

// File: sim/test_debug_breakpoint_serial_port.sv
`timescale 1ns/100ps
`include "dbg_regs.svh"
module test_debug_breakpoint_serial_port
    import dbg_pkg::*;
;
    logic        clock, rst_n, bus_valid, pc_cond_l1, pc_cond_l2, data_cond_l1, data_cond_l2;
    logic [31:0] bus_addr, debug_write_instr_data, lo, hi, sl, sh;
    logic [2:0]  xfer_modifier_field;
    logic [1:0]  xfer_type_field;
    logic        debug_write_instr_valid, dev_serial_clock, dev_serial_in, dev_serial_out;
    logic [4:0]  debug_write_instr_reg;
    logic [3:0]  debug_data_pins;
    logic        halt_req, debug_irq, fired;
    logic [2:0]  tmtab [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
    int          n_errors, checks_done, cyc;
    localparam packet_t FULL = 17'h1_ffff;

    debug_breakpoint_serial_port dut (.clock(clock), .rst_n(rst_n), .bus_valid(bus_valid),
        .bus_addr(bus_addr), .xfer_modifier_field(xfer_modifier_field),
        .xfer_type_field(xfer_type_field), .pc_cond_l1(pc_cond_l1), .pc_cond_l2(pc_cond_l2),
        .data_cond_l1(data_cond_l1), .data_cond_l2(data_cond_l2),
        .debug_write_instr_valid(debug_write_instr_valid),
        .debug_write_instr_reg(debug_write_instr_reg),
        .debug_write_instr_data(debug_write_instr_data), .dev_serial_clock(dev_serial_clock),
        .dev_serial_in(dev_serial_in), .dev_serial_out(dev_serial_out),
        .debug_data_pins(debug_data_pins), .halt_req(halt_req), .debug_irq(debug_irq));
    dev_system_model host (.dev_serial_clock(dev_serial_clock), .dev_serial_in(dev_serial_in),
        .dev_serial_out(dev_serial_out));

    always #5 clock = ~clock;

    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic dwr(input logic [4:0] rg, input logic [31:0] d);
        @(negedge clock);
        debug_write_instr_valid = 1'b1;
        debug_write_instr_reg   = rg;
        debug_write_instr_data  = d;
        @(negedge clock);
        debug_write_instr_valid = 1'b0;
    endtask : dwr

    task automatic pkt(input packet_t c, input packet_t e, input packet_t m,
                       input realtime gap = 600.0, input realtime half = 62.5);
        packet_t r;
        host.xfer(c, gap, half, r);
        if (m != 0)
            check("response", 32'(r & m), 32'(e & m));
    endtask : pkt

    task automatic swr(input logic [4:0] rg, input logic [31:0] d, input packet_t e0, input packet_t m0);
        pkt({1'b0, `CMD_WR_REG, 3'h0, rg}, e0, m0);
        pkt({1'b0, d[31:16]}, `RSP_NOT_READY, FULL, 600.0, 125.0);
        pkt({1'b0, d[15:0]}, `RSP_NOT_READY, FULL);
    endtask : swr

    task automatic srd(input logic [4:0] rg, input packet_t e0, input packet_t m0,
                       input logic [31:0] ed, input logic [31:0] dm);
        pkt({1'b0, `CMD_RD_REG, 3'h0, rg}, e0, m0);
        pkt(17'h0, {1'b0, ed[31:16]}, {1'b1, dm[31:16]});
        pkt(17'h0, {1'b0, ed[15:0]}, {1'b1, dm[15:0]});
    endtask : srd

    function automatic logic exp_fire(logic [1:0] mode, logic [2:0] tmp, logic level_trigger_logic, logic en);
        logic r;
        r = (mode == 2'h1) ? bus_addr == lo : (mode == 2'h2) ? (bus_addr >= lo && bus_addr <= hi)
            : (bus_addr < lo || bus_addr > hi);
        r = r && xfer_modifier_field == tmp && xfer_type_field == 2'h0;
        return bus_valid && en && (level_trigger_logic ? pc_cond_l1 || (r && data_cond_l1)
                                       : pc_cond_l1 && r && data_cond_l1);
    endfunction : exp_fire

    // Limits are loaded only with both levels disabled, so no spurious hit
    task automatic pass(input int p);
        logic [31:0] tdef;
        logic [1:0]  rsel, mode;
        logic        level_trigger_logic, en, f;
        rsel = 2'(p);
        level_trigger_logic  = p[2];
        en   = p < 8;
        mode = 2'(1 + p % 3);
        tdef = {rsel, 15'h0, level_trigger_logic, en, 6'h0, mode, 2'h0, tmtab[p % 4]};
        dwr(`DRC_TRIG_DEF, 32'h0);
        if (p > 0) begin
            lo = ($urandom % 32'h7000_0000) + 32'h100;
            hi = lo + ($urandom % 64);
            dwr(`DRC_ABL, lo);
            dwr(`DRC_ABH, hi);
        end
        dwr(`DRC_TRIG_DEF, tdef);
        f     = 1'b0;
        fired = 1'b0;
        for (int i = 0; i <= 40; i++) begin
            @(negedge clock);
            check("pins", 32'(debug_data_pins), f ? 32'hf : 32'h0);
            check("halt", 32'(halt_req), 32'(f && rsel == 2'h1));
            check("irq", 32'(debug_irq), 32'(f && rsel == 2'h2));
            fired |= f;
            bus_valid = i < 40;
            case ($urandom % 5)
                0: bus_addr = lo;
                1: bus_addr = hi;
                2: bus_addr = lo - 32'h1;
                3: bus_addr = hi + 32'h1;
                default: bus_addr = lo + ($urandom % (hi - lo + 32'h1));
            endcase
            xfer_modifier_field = ($urandom % 2) ? tmtab[p % 4] : 3'($urandom);
            xfer_type_field = ($urandom % 4 == 0) ? 2'($urandom) : 2'h0;
            pc_cond_l1   = ($urandom % 3 == 0) && i < 40;
            pc_cond_l2   = 1'($urandom);
            data_cond_l1 = ($urandom % 4) != 0;
            data_cond_l2 = 1'($urandom);
            f = exp_fire(mode, tmtab[p % 4], level_trigger_logic, en);
        end
        done("trigger pass");
    endtask : pass

    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        {bus_valid, bus_addr, xfer_modifier_field, xfer_type_field} = '0;
        {pc_cond_l1, pc_cond_l2, data_cond_l1, data_cond_l2} = 4'h0;
        {debug_write_instr_valid, debug_write_instr_reg, debug_write_instr_data} = '0;
        void'($urandom(32'hb501de17));
        repeat (8) @(negedge clock);
        check("reset outputs", 32'({dev_serial_out, debug_data_pins, halt_req, debug_irq}), 32'h0);
        rst_n = 1'b1;
        sl = ($urandom % 32'h7000_0000) + 32'h100;
        sh = sl + ($urandom % 64);
        swr(`DRC_ABH, sh, `RSP_OK, FULL);
        swr(`DRC_ABL, sl, `RSP_OK, FULL);
        srd(`DRC_ABH, `RSP_OK, FULL, sh, 32'hffff_ffff);
        pkt({1'b0, `CMD_RD_REG, 3'h0, `DRC_ABL}, 17'h0, 17'h0);
        pkt({1'b1, `CMD_RD_REG, 3'h0, `DRC_TRIG_DEF}, `RSP_ILLEGAL, FULL);
        srd(`DRC_STATUS, `RSP_ILLEGAL, FULL, 32'h0, 32'hf000_0000);
        done("serial registers");
        lo = sl;
        hi = sh;
        pass(0);
        // Serial reads only after the debug-write traffic has ended
        srd(`DRC_STATUS, 17'h0, 17'h0, fired ? 32'h3000_0000 : 32'h0, 32'hf000_0000);
        dwr(`DRC_TRIG_DEF, 32'h0);
        srd(`DRC_STATUS, 17'h0, 17'h0, 32'h0, 32'hf000_0000);
        done("status clear");
        for (int p = 1; p < 9; p++)
            pass(p);
        // Both levels on: level two alone stays quiet until level one has armed it
        pc_cond_l2 = 1'b0;
        dwr(`DRC_TRIG_DEF, 32'h6000_e000);
        @(negedge clock);
        pc_cond_l2 = 1'b1;
        @(negedge clock);
        check("unarmed halt", 32'(halt_req), 32'h0);
        pc_cond_l2 = 1'b0;
        pc_cond_l1 = 1'b1;
        @(negedge clock);
        pc_cond_l1 = 1'b0;
        pc_cond_l2 = 1'b1;
        @(negedge clock);
        pc_cond_l2 = 1'b0;
        check("armed halt", 32'(halt_req), 32'h1);
        check("armed pins", 32'(debug_data_pins), 32'hf);
        done("two levels");
        swr(`DRC_TRIG_DEF, 32'h0, 17'h0, 17'h0);
        srd(`DRC_TRIG_DEF, `RSP_OK, FULL, 32'h0, 32'hffff_ffff);
        pkt({1'b0, `CMD_RD_REG, 3'h0, `DRC_STATUS}, `RSP_NOT_READY, FULL, 100.0);
        done("packet spacing");
        complete_run();
    end
endmodule : test_debug_breakpoint_serial_port
